// file: inc/fws_cyc_if.sv
// Purpose: request/answer channel between the sequencer and the bus cycle engine
// Assumes: req is a level held while more flash cycles are wanted
// Notes:   done is a one-cycle pulse; rdata is valid with it on read cycles
`timescale 1ns/1ps
`default_nettype none
interface fws_cyc_if #(
    parameter int AW = 18,
    parameter int DW = 8
);
    logic          req;
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic          done;
    modport ctl (output req, output we, output addr, output wdata, input rdata, input done);
    modport eng (input req, input we, input addr, input wdata, output rdata, output done);
endinterface
`default_nettype wire

// file: inc/fws_pkg.sv
// Purpose: shared constants and types for the flash status-polling host controller
// Assumes: 8-bit parallel flash bus, 32-bit classic Wishbone register port
// Notes:   register offsets are byte addresses; every register sits in one aligned word
`default_nettype none
package fws_pkg;
    // register byte offsets
    localparam logic [4:0] REG_OP    = 5'h00;
    localparam logic [4:0] REG_ADDR  = 5'h04;
    localparam logic [4:0] REG_WDATA = 5'h08;
    localparam logic [4:0] REG_STAT  = 5'h0C;
    localparam logic [4:0] REG_CFG   = 5'h10;
    localparam int         REG_LSB   = 5;        // first address bit above the map
    // operation codes written to the op register
    localparam logic [2:0] OP_WRITE = 3'h1;
    localparam logic [2:0] OP_READ  = 3'h2;
    localparam logic [2:0] OP_POLL  = 3'h3;
    localparam logic [2:0] OP_RESET = 3'h4;
    localparam logic [2:0] OP_SADD  = 3'h5;
    localparam logic [2:0] OP_ABORT = 3'h6;
    // status bit positions on the flash data bus
    localparam int BIT_POLLING = 7;
    localparam int BIT_TOGGLE  = 6;
    localparam int BIT_TIMEOUT = 5;
    localparam int BIT_WINDOW  = 3;
    localparam int BIT_SECTOR  = 2;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    // status register field positions
    localparam int ST_BUSY    = 0;
    localparam int ST_OK      = 1;
    localparam int ST_FAIL    = 2;
    localparam int ST_ABORTED = 3;
    localparam int ST_WINDOW  = 4;
    localparam int ST_MAYREJ  = 5;
    localparam int ST_REJPRE  = 6;
    localparam int ST_STALE   = 7;
    localparam int ST_RDATA   = 8;
    // gap allowed between extra sector erase commands
    localparam int GAP_US      = 50;
    localparam int CLK_MHZ     = 250;
    localparam int GAP_CYC_DEF = GAP_US * CLK_MHZ;
    // flash bus cycle shape, in clock cycles
    localparam int SETUP_CYC_DEF = 2;
    localparam int PULSE_CYC_DEF = 4;
    localparam int RECOV_CYC_DEF = 2;
    typedef enum logic [3:0] {
        ST_IDLE, ST_WR, ST_RD, ST_T1, ST_T2, ST_T3, ST_RST, ST_WPRE, ST_WCMD, ST_WPOST
    } fws_state_e;
    typedef enum logic [1:0] {
        PH_IDLE, PH_SETUP, PH_STROBE, PH_RECOV
    } fws_phase_e;
endpackage
`default_nettype wire

// file: rtl/fws_bus_cycle.sv
// Purpose: run one flash read or write cycle on the parallel pins per request
// Assumes: flash data inputs synchronous to clk_i
// Notes:   every read is framed by both chip select and output strobe
`timescale 1ns/1ps
`default_nettype none
module fws_bus_cycle #(
    parameter int AW        = 18,
    parameter int DW        = 8,
    parameter int SETUP_CYC = fws_pkg::SETUP_CYC_DEF,
    parameter int PULSE_CYC = fws_pkg::PULSE_CYC_DEF,
    parameter int RECOV_CYC = fws_pkg::RECOV_CYC_DEF
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    fws_cyc_if.eng             cif,
    output logic [AW-1:0]      fl_addr_o,
    output logic [DW-1:0]      fl_dq_o,
    output logic               fl_dq_oe_o,
    input  wire logic [DW-1:0] fl_dq_i,
    output logic               fl_ce_n_o,
    output logic               fl_oe_n_o,
    output logic               fl_we_n_o
);
    localparam logic [3:0] SETUP_LD = 4'(SETUP_CYC - 1);
    localparam logic [3:0] PULSE_LD = 4'(PULSE_CYC - 1);
    localparam logic [3:0] RECOV_LD = 4'(RECOV_CYC - 1);

    fws_pkg::fws_phase_e phase_reg;
    logic [3:0]          cnt_reg;
    logic                we_reg;
    logic [DW-1:0]       rdata_reg;
    logic                done_reg;

    // done blocks a restart so a stale request level is never taken twice
    wire start    = cif.req && !done_reg;
    wire cnt_zero = (cnt_reg == 4'h0);

    assign cif.rdata = rdata_reg;
    assign cif.done  = done_reg;

    // cycle sequencer: setup, strobe, recovery with all strobes high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_reg  <= fws_pkg::PH_IDLE;
            cnt_reg    <= 4'h0;
            we_reg     <= 1'b0;
            rdata_reg  <= '0;
            done_reg   <= 1'b0;
            fl_addr_o  <= '0;
            fl_dq_o    <= '0;
            fl_dq_oe_o <= 1'b0;
            fl_ce_n_o  <= 1'b1;
            fl_oe_n_o  <= 1'b1;
            fl_we_n_o  <= 1'b1;
        end else begin
            done_reg <= 1'b0;
            case (phase_reg)
                fws_pkg::PH_IDLE: begin
                    if (start) begin
                        fl_addr_o  <= cif.addr;
                        fl_dq_o    <= cif.wdata;
                        fl_dq_oe_o <= cif.we;
                        we_reg     <= cif.we;
                        fl_ce_n_o  <= 1'b0;
                        cnt_reg    <= SETUP_LD;
                        phase_reg  <= fws_pkg::PH_SETUP;
                    end
                end
                fws_pkg::PH_SETUP: begin
                    if (cnt_zero) begin
                        fl_we_n_o <= !we_reg;
                        fl_oe_n_o <= we_reg;
                        cnt_reg   <= PULSE_LD;
                        phase_reg <= fws_pkg::PH_STROBE;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                fws_pkg::PH_STROBE: begin
                    if (cnt_zero) begin
                        if (!we_reg) begin
                            rdata_reg <= fl_dq_i;      // sampled while strobe still low
                        end
                        fl_we_n_o <= 1'b1;
                        fl_oe_n_o <= 1'b1;
                        fl_ce_n_o <= 1'b1;
                        cnt_reg   <= RECOV_LD;
                        phase_reg <= fws_pkg::PH_RECOV;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                fws_pkg::PH_RECOV: begin
                    if (cnt_zero) begin
                        fl_dq_oe_o <= 1'b0;            // data held past the rising strobe
                        done_reg   <= 1'b1;
                        phase_reg  <= fws_pkg::PH_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                default: phase_reg <= fws_pkg::PH_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: rtl/fws_host.sv
// Purpose: host controller that polls write status of a parallel flash and recovers from failures
// Assumes: software drives it over classic Wishbone; flash pins synchronous to clk_i
// Notes:   one operation at a time; only abort is taken while busy
//
// What this block does
// - host polls at a valid sector/program address
// - host reads twice, compares, done if equal
// - toggling with timeout bit: recheck, then reset
// - leaving polling restarts at first double read
// - after timeout, reset command restores array read
// - skip window check only under 50 us gaps (this block never skips it; a stale flag marks gaps past the limit)
// - host checks window before and after sector adds
//
// The placing of the registers and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fws_host #(
    parameter int          FA_W      = 18,
    parameter int          DQ_W      = 8,
    parameter int          WB_AW     = 8,
    parameter int unsigned GAP_CYC   = fws_pkg::GAP_CYC_DEF,
    parameter int          SETUP_CYC = fws_pkg::SETUP_CYC_DEF,
    parameter int          PULSE_CYC = fws_pkg::PULSE_CYC_DEF,
    parameter int          RECOV_CYC = fws_pkg::RECOV_CYC_DEF
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [WB_AW-1:0] wb_adr_i,
    input  wire logic [31:0]      wb_dat_i,
    input  wire logic [3:0]       wb_sel_i,
    output logic [31:0]           wb_dat_o,
    output logic                  wb_ack_o,
    output logic [FA_W-1:0]       fl_addr_o,
    output logic [DQ_W-1:0]       fl_dq_o,
    output logic                  fl_dq_oe_o,
    input  wire logic [DQ_W-1:0]  fl_dq_i,
    output logic                  fl_ce_n_o,
    output logic                  fl_oe_n_o,
    output logic                  fl_we_n_o
);
    localparam int GAP_W = $clog2(GAP_CYC + 1);
    localparam logic [GAP_W-1:0] GAP_LIM = GAP_W'(GAP_CYC);

    fws_cyc_if #(.AW(FA_W), .DW(DQ_W)) cif ();

    fws_bus_cycle #(
        .AW        (FA_W),
        .DW        (DQ_W),
        .SETUP_CYC (SETUP_CYC),
        .PULSE_CYC (PULSE_CYC),
        .RECOV_CYC (RECOV_CYC)
    ) u_cycle (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .cif        (cif),
        .fl_addr_o  (fl_addr_o),
        .fl_dq_o    (fl_dq_o),
        .fl_dq_oe_o (fl_dq_oe_o),
        .fl_dq_i    (fl_dq_i),
        .fl_ce_n_o  (fl_ce_n_o),
        .fl_oe_n_o  (fl_oe_n_o),
        .fl_we_n_o  (fl_we_n_o)
    );

    // software registers
    logic [FA_W-1:0] addr_reg;
    logic [DQ_W-1:0] wdata_reg;
    logic            sel_sector_reg;
    logic [DQ_W-1:0] last_rd_reg;
    logic            ack_reg;
    logic [31:0]     dat_o_reg;
    // sequencer state
    fws_pkg::fws_state_e state_reg, state_next;
    logic            prev_reg, prev_next;
    logic            ok_reg, ok_next;
    logic            fail_reg, fail_next;
    logic            aborted_reg, aborted_next;
    logic            abort_reg, abort_next;
    logic            win_reg, win_next;
    logic            mayrej_reg, mayrej_next;
    logic            rejpre_reg, rejpre_next;
    logic [GAP_W-1:0] gap_reg, gap_next;
    logic            req_reg;
    logic            cyc_we_reg;
    logic [FA_W-1:0] cyc_addr_reg;
    logic [DQ_W-1:0] cyc_wdata_reg;

    // bus decode: one-cycle answer, unmapped reads return zero and writes drop
    wire take     = wb_cyc_i && wb_stb_i && !ack_reg;
    wire wr_take  = take && wb_we_i;
    wire in_map   = (wb_adr_i[WB_AW-1:fws_pkg::REG_LSB] == '0);
    wire [4:0] ofs = wb_adr_i[4:0];
    wire hit_op   = in_map && (ofs == fws_pkg::REG_OP);
    wire hit_addr = in_map && (ofs == fws_pkg::REG_ADDR);
    wire hit_wdat = in_map && (ofs == fws_pkg::REG_WDATA);
    wire hit_stat = in_map && (ofs == fws_pkg::REG_STAT);
    wire hit_cfg  = in_map && (ofs == fws_pkg::REG_CFG);
    wire op_wr    = wr_take && hit_op && wb_sel_i[0];
    wire [2:0] op = wb_dat_i[2:0];
    wire busy     = (state_reg != fws_pkg::ST_IDLE);
    wire [31:0] lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [FA_W-1:0] addr_mask = lane_mask[FA_W-1:0];
    wire [FA_W-1:0] addr_wr = (addr_reg & ~addr_mask) | (wb_dat_i[FA_W-1:0] & addr_mask);

    // status read back; busy and all flags come from the sequencer itself
    logic [7:0] stat_bits;
    always_comb begin
        stat_bits                       = 8'h00;
        stat_bits[fws_pkg::ST_BUSY]    = busy;
        stat_bits[fws_pkg::ST_OK]      = ok_reg;
        stat_bits[fws_pkg::ST_FAIL]    = fail_reg;
        stat_bits[fws_pkg::ST_ABORTED] = aborted_reg;
        stat_bits[fws_pkg::ST_WINDOW]  = win_reg;
        stat_bits[fws_pkg::ST_MAYREJ]  = mayrej_reg;
        stat_bits[fws_pkg::ST_REJPRE]  = rejpre_reg;
        stat_bits[fws_pkg::ST_STALE]   = (gap_reg == GAP_LIM);
    end
    wire [31:0] stat_word = {{(24 - DQ_W){1'b0}}, last_rd_reg, stat_bits};
    wire [31:0] rd_mux = hit_addr ? {{(32 - FA_W){1'b0}}, addr_reg} :
                         hit_wdat ? {{(32 - DQ_W){1'b0}}, wdata_reg} :
                         hit_stat ? stat_word :
                         hit_cfg  ? {31'h0, sel_sector_reg} : 32'h0000_0000;

    // poll bit: primary toggle bit, or sector toggle bit for per-sector erase status
    wire tog_bit  = sel_sector_reg ? cif.rdata[fws_pkg::BIT_SECTOR] : cif.rdata[fws_pkg::BIT_TOGGLE];
    wire same     = (tog_bit == prev_reg);
    wire tmo_bit  = cif.rdata[fws_pkg::BIT_TIMEOUT];
    wire win_bit  = cif.rdata[fws_pkg::BIT_WINDOW];
    wire done     = cif.done;

    // sequencer: next state and result flags
    always_comb begin
        state_next   = state_reg;
        prev_next    = prev_reg;
        ok_next      = ok_reg;
        fail_next    = fail_reg;
        aborted_next = aborted_reg;
        abort_next   = abort_reg || (op_wr && busy && (op == fws_pkg::OP_ABORT));
        win_next     = win_reg;
        mayrej_next  = mayrej_reg;
        rejpre_next  = rejpre_reg;
        case (state_reg)
            fws_pkg::ST_IDLE: begin
                abort_next = 1'b0;
                if (op_wr && (op != fws_pkg::OP_ABORT) && (op != 3'h0) && (op != 3'h7)) begin
                    ok_next      = 1'b0;
                    fail_next    = 1'b0;
                    aborted_next = 1'b0;
                    mayrej_next  = 1'b0;
                    rejpre_next  = 1'b0;
                    case (op)
                        fws_pkg::OP_WRITE: state_next = fws_pkg::ST_WR;
                        fws_pkg::OP_READ:  state_next = fws_pkg::ST_RD;
                        fws_pkg::OP_POLL:  state_next = fws_pkg::ST_T1;
                        fws_pkg::OP_RESET: state_next = fws_pkg::ST_RST;
                        fws_pkg::OP_SADD:  state_next = fws_pkg::ST_WPRE;
                        default:           state_next = fws_pkg::ST_IDLE;
                    endcase
                end
            end
            fws_pkg::ST_WR, fws_pkg::ST_RD: begin
                if (done) begin
                    ok_next    = 1'b1;
                    state_next = fws_pkg::ST_IDLE;
                end
            end
            fws_pkg::ST_T1: begin
                if (done) begin
                    prev_next  = tog_bit;
                    state_next = fws_pkg::ST_T2;
                end
            end
            fws_pkg::ST_T2: begin
                if (done) begin
                    prev_next = tog_bit;
                    if (same) begin
                        ok_next    = 1'b1;
                        state_next = fws_pkg::ST_IDLE;
                    end else if (tmo_bit) begin
                        state_next = fws_pkg::ST_T3;
                    end else if (abort_reg) begin
                        aborted_next = 1'b1;
                        state_next   = fws_pkg::ST_IDLE;
                    end
                end
            end
            fws_pkg::ST_T3: begin
                if (done) begin
                    if (same) begin
                        ok_next    = 1'b1;
                        state_next = fws_pkg::ST_IDLE;
                    end else begin
                        fail_next  = 1'b1;
                        state_next = fws_pkg::ST_RST;
                    end
                end
            end
            fws_pkg::ST_RST: begin
                if (done) begin
                    ok_next    = !fail_reg;
                    state_next = fws_pkg::ST_IDLE;
                end
            end
            fws_pkg::ST_WPRE: begin
                if (done) begin
                    win_next = win_bit;
                    if (win_bit) begin
                        rejpre_next = 1'b1;
                        state_next  = fws_pkg::ST_IDLE;
                    end else begin
                        state_next = fws_pkg::ST_WCMD;
                    end
                end
            end
            fws_pkg::ST_WCMD: begin
                if (done) begin
                    state_next = fws_pkg::ST_WPOST;
                end
            end
            fws_pkg::ST_WPOST: begin
                if (done) begin
                    win_next    = win_bit;
                    mayrej_next = win_bit;
                    ok_next     = !win_bit;
                    state_next  = fws_pkg::ST_IDLE;
                end
            end
            default: state_next = fws_pkg::ST_IDLE;
        endcase
    end

    // the window check is never skipped; the stale flag tells software the gap ran past the limit
    assign gap_next = (state_reg == fws_pkg::ST_WCMD && done) ? '0 :
                      (gap_reg == GAP_LIM) ? gap_reg : gap_reg + 1'b1;

    // cycle request follows the next state; all polls use the software address
    wire nx_cyc   = (state_next != fws_pkg::ST_IDLE);
    wire nx_rst   = (state_next == fws_pkg::ST_RST);
    wire nx_we    = nx_rst || (state_next == fws_pkg::ST_WR) || (state_next == fws_pkg::ST_WCMD);
    wire [FA_W-1:0] nx_addr = nx_rst ? '0 : addr_reg;
    wire [DQ_W-1:0] nx_wdat = nx_rst ? fws_pkg::CMD_RESET : wdata_reg;

    assign cif.req   = req_reg;
    assign cif.we    = cyc_we_reg;
    assign cif.addr  = cyc_addr_reg;
    assign cif.wdata = cyc_wdata_reg;
    assign wb_ack_o  = ack_reg;
    assign wb_dat_o  = dat_o_reg;

    // bus slave registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg        <= 1'b0;
            dat_o_reg      <= 32'h0000_0000;
            addr_reg       <= '0;
            wdata_reg      <= '0;
            sel_sector_reg <= 1'b0;
        end else begin
            ack_reg <= take;
            if (take && !wb_we_i) begin
                dat_o_reg <= rd_mux;
            end
            if (wr_take && hit_addr && !busy) begin
                addr_reg <= addr_wr;                   // frozen while busy so polls stay on one address
            end
            if (wr_take && hit_wdat && wb_sel_i[0] && !busy) begin
                wdata_reg <= wb_dat_i[DQ_W-1:0];
            end
            if (wr_take && hit_cfg && wb_sel_i[0] && !busy) begin
                sel_sector_reg <= wb_dat_i[0];
            end
        end
    end

    // sequencer registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg     <= fws_pkg::ST_IDLE;
            prev_reg      <= 1'b0;
            ok_reg        <= 1'b0;
            fail_reg      <= 1'b0;
            aborted_reg   <= 1'b0;
            abort_reg     <= 1'b0;
            win_reg       <= 1'b0;
            mayrej_reg    <= 1'b0;
            rejpre_reg    <= 1'b0;
            gap_reg       <= '0;
            req_reg       <= 1'b0;
            cyc_we_reg    <= 1'b0;
            cyc_addr_reg  <= '0;
            cyc_wdata_reg <= '0;
            last_rd_reg   <= '0;
        end else begin
            state_reg     <= state_next;
            prev_reg      <= prev_next;
            ok_reg        <= ok_next;
            fail_reg      <= fail_next;
            aborted_reg   <= aborted_next;
            abort_reg     <= abort_next;
            win_reg       <= win_next;
            mayrej_reg    <= mayrej_next;
            rejpre_reg    <= rejpre_next;
            gap_reg       <= gap_next;
            req_reg       <= nx_cyc;
            cyc_we_reg    <= nx_we;
            cyc_addr_reg  <= nx_addr;
            cyc_wdata_reg <= nx_wdat;
            if (done && !cyc_we_reg) begin
                last_rd_reg <= cif.rdata;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/fws_flash_model.sv
// Purpose: behavioural flash giving status reads
// Assumes: a read ends when the output strobe rises
// Notes: a released bus shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module fws_flash_model (
    input  wire logic       ce_n_i,
    input  wire logic       oe_n_i,
    input  wire logic       we_n_i,
    input  wire logic [7:0] dq_i,
    input  wire logic       go_i,
    input  wire logic [7:0] busy_i,
    input  wire logic       fail_i,
    output logic [7:0]      dq_o,
    output logic [15:0]     n_rd_o
);
    logic [7:0] left = 8'h00;
    logic       tog  = 1'b0;
    logic       to   = 1'b0;
    logic [7:0] last = 8'h00;
    logic [7:0] stat;
    // status while running, array byte once done
    assign stat = (left != 8'h00 || to) ? {1'b0, tog, to, 1'b0, left == 8'h00, tog, 2'h0} : 8'h5E;
    assign dq_o = (!ce_n_i && !oe_n_i) ? stat : ~last;
    initial n_rd_o = 16'h0000;
    // a busy run stands for any program or erase, protected or suspended alike
    // start polarity is the inverse of busy_i bit 0, whatever the last status read; the host must not care
    always @(posedge go_i) begin
        left = busy_i;
        to = fail_i;
        tog = ~busy_i[0];
    end
    // each finished read flips the toggle bits while busy
    always @(posedge oe_n_i) begin
        last = stat;
        n_rd_o = n_rd_o + 16'h0001;
        if (left != 8'h00 || to) tog = ~tog;
        if (left != 8'h00) left = left - 8'h01;
    end
    always @(posedge we_n_i) begin
        if (dq_i == 8'hF0) to = 1'b0;
    end
endmodule
`default_nettype wire

// file: tb/fws_host_monitor.sv
// Purpose: pin checks on the flash host
// Assumes: top ports only
// Notes: bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module fws_host_monitor #(
    parameter int FA_W = 18
) (
    input wire logic            clk_i,
    input wire logic            rst_i,
    input wire logic            wb_cyc_i,
    input wire logic            wb_stb_i,
    input wire logic            wb_ack_o,
    input wire logic [FA_W-1:0] fl_addr_o,
    input wire logic [7:0]      fl_dq_o,
    input wire logic            fl_dq_oe_o,
    input wire logic            fl_ce_n_o,
    input wire logic            fl_oe_n_o,
    input wire logic            fl_we_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // read and write framing on the flash pins
    property p_excl; !(!fl_oe_n_o && !fl_we_n_o); endproperty
    a_excl: assert property (p_excl) else $error("strobes overlap");
    property p_frame; !fl_oe_n_o |-> !fl_ce_n_o; endproperty
    a_frame: assert property (p_frame) else $error("read outside select");
    property p_setup; $fell(fl_ce_n_o) |-> ##2 (!fl_oe_n_o || !fl_we_n_o); endproperty
    a_setup: assert property (p_setup) else $error("strobe late");
    property p_pulse; $fell(fl_oe_n_o) |-> !fl_oe_n_o [*4] ##1 fl_oe_n_o; endproperty
    a_pulse: assert property (p_pulse) else $error("read pulse length");
    // a separate read per sample, so the device sees each one
    property p_gap; $rose(fl_ce_n_o) |-> fl_ce_n_o [*3]; endproperty
    a_gap: assert property (p_gap) else $error("reads merged");
    property p_addr; !fl_oe_n_o |-> $stable(fl_addr_o); endproperty
    a_addr: assert property (p_addr) else $error("address moved");
    property p_wdrv; !fl_we_n_o |-> fl_dq_oe_o && $stable(fl_dq_o); endproperty
    a_wdrv: assert property (p_wdrv) else $error("write data loose");
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    c_read: cover property ($fell(fl_oe_n_o));
    c_rst: cover property (!fl_we_n_o && fl_dq_o == 8'hF0);
    c_ack: cover property (wb_ack_o);
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Purpose: self-checking bench for the flash host
// Assumes: behavioural flash on the far side
// Notes: gap count cut to 40 cycles to keep runs short
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, fail = 1'b0;
    logic        fdoe, ce_n, oe_n, we_n, ack;
    logic [7:0]  adr = 8'h00, busy = 8'h00, fdo, fdi;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [17:0] fa;
    logic [15:0] nrd, n0, seed = 16'h0D47;
    int          n_errors = 0, check_count = 0, i;
    always #2 clk_i = ~clk_i;
    fws_host #(.GAP_CYC(40)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack), .fl_addr_o(fa),
        .fl_dq_o(fdo), .fl_dq_oe_o(fdoe), .fl_dq_i(fdi), .fl_ce_n_o(ce_n), .fl_oe_n_o(oe_n), .fl_we_n_o(we_n));
    fws_flash_model fm_u (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .dq_i(fdo), .go_i(go), .busy_i(busy),
        .fail_i(fail), .dq_o(fdi), .n_rd_o(nrd));
    task automatic close_out;
        if (n_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // one classic cycle: hold until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        if (k == 20) begin n_errors++; close_out(); end
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic go_op(input logic [7:0] l, input logic f);
        busy <= l; fail <= f; go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
    endtask
    // start an op and read status until busy clears
    task automatic op_wait(input logic [2:0] op);
        int k;
        n0 = nrd;
        wb(1'b1, fws_pkg::REG_OP, {29'h0, op});
        q = 32'h1;
        for (k = 0; k < 1000 && q[0] !== 1'b0; k++) wb(1'b0, fws_pkg::REG_STAT, 32'h0);
        if (k == 1000) begin n_errors++; close_out(); end
    endtask
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 8'h14, 32'h0); chk(q, 32'h0);
        wb(1'b0, fws_pkg::REG_OP, 32'h0); chk(q, 32'h0);
        // random busy lengths, addresses and polled bit
        for (i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            wb(1'b1, fws_pkg::REG_CFG, {31'h0, seed[3]});
            wb(1'b1, fws_pkg::REG_ADDR, {14'h0, seed, 2'h1});
            go_op({5'h0, seed[2:0]}, 1'b0);
            op_wait(fws_pkg::OP_POLL);
            chk({20'h0, q[15:8], q[3:0]}, 32'h5E2);
            chk(32'(fa), 32'({seed, 2'h1}));
            chk(32'(nrd - n0), 32'(seed[2:0]) + 32'h2);
        end
        go_op(8'h00, 1'b1);
        op_wait(fws_pkg::OP_POLL);
        chk(32'(q[3:0]), 32'h4); chk(32'(nrd - n0), 32'h3);
        chk(32'(fa), 32'h0);
        op_wait(fws_pkg::OP_POLL);
        chk(32'(q[3:0]), 32'h2); chk(32'(nrd - n0), 32'h2);
        go_op(8'h3C, 1'b0);
        wb(1'b1, fws_pkg::REG_OP, {29'h0, fws_pkg::OP_POLL});
        op_wait(fws_pkg::OP_ABORT); chk(32'(q[3:0]), 32'h8);
        op_wait(fws_pkg::OP_POLL); chk(32'(q[3:0]), 32'h2);
        wb(1'b1, fws_pkg::REG_WDATA, 32'h30);
        op_wait(fws_pkg::OP_SADD); chk(32'(q[6]), 32'h1);
        go_op(8'h06, 1'b0);
        op_wait(fws_pkg::OP_SADD); chk(32'(q[6:5]), 32'h0);
        go_op(8'h01, 1'b0);
        op_wait(fws_pkg::OP_SADD); chk(32'(q[7:5]), 32'h1);
        repeat (40) @(posedge clk_i);
        wb(1'b0, fws_pkg::REG_STAT, 32'h0); chk(32'(q[7]), 32'h1);
        op_wait(fws_pkg::OP_READ); chk(32'({q[15:8], q[3:0]}), 32'h5E2);
        op_wait(fws_pkg::OP_WRITE); chk(32'({fdo, q[3:0]}), 32'h302);
        op_wait(fws_pkg::OP_RESET); chk(32'({fdo, q[3:0]}), 32'hF02);
        close_out();
    end
endmodule
bind fws_host fws_host_monitor #(.FA_W(FA_W)) mon_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .fl_addr_o(fl_addr_o), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o),
    .fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o));
`default_nettype wire
